// ---- rtl/card_host_access.sv ----
// Host controller driving a removable storage card through its socket strobes
`timescale 1ns/10ps
`include "card_host_regs.svh"
module card_host_access
  import card_host_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire map_mode_type mode_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic attr_in,
  input wire size_type size_in,
  input wire logic [10:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic byte_mode_in,
  output logic ready_out,
  output logic done_out,
  output logic refused_out,
  output logic [15:0] rdata_out,
  output logic word_expected_out,
  input wire logic [15:0] data_lanes_in,
  input wire logic word_cycle_indicator_n_in,
  output logic [15:0] data_lanes_out,
  output logic [15:0] data_lanes_oe_out,
  output logic [10:0] addr_pins_out,
  output logic byte_select_lsb_out,
  output logic low_lane_enable_n_out,
  output logic high_lane_enable_n_out,
  output logic attr_select_n_out,
  output logic output_enable_n_out,
  output logic write_enable_n_out,
  output logic io_read_strobe_n_out,
  output logic io_write_strobe_n_out
);
  state_type state_r, state_nxt;
  logic [3:0] cnt_r;
  logic write_r, attr_r, fixed_r;
  size_type size_r;
  logic [10:0] addr_r;
  logic [15:0] wdata_r, rdata_r;
  logic done_r, refused_r;
  logic [15:0] lanes_meta_r, lanes_sync_r;
  logic ind_meta_r, ind_sync_r;
  logic low_en_n, high_en_n, lsb;
  logic [15:0] lanes_w, lane_oe_w;

  // Request checks: fixed mode refuses attribute (incl. config-register) access
  wire fixed_req = (mode_in == MAP_FIXED);
  wire cfg_hit = attr_in && (addr_in >= `CFG_BASE_ADDR) && (addr_in <= `CFG_LAST_ADDR);
  wire bad_fixed = fixed_req && (attr_in || cfg_hit);
  // Fixed data register stays 16-bit until byte mode is commanded
  wire bad_width = fixed_req && !byte_mode_in && (addr_in == `DATA_REG_ADDR)
                   && (size_in != SIZE_WORD);
  wire bad_odd_fixed = fixed_req && (size_in == SIZE_ODD) && (addr_in != `ALT_STATUS_ADDR);
  wire refuse = bad_fixed || bad_width || bad_odd_fixed;
  wire idle = (state_r == ST_IDLE);
  wire accept = idle && req_in && !refuse;
  assign ready_out = idle;

  // Sequencer: setup, one strobe, hold
  wire cnt_end = (cnt_r == 4'h0);
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = accept ? ST_SETUP : ST_IDLE;
      ST_SETUP: state_nxt = cnt_end ? ST_STROBE : ST_SETUP;
      ST_STROBE: state_nxt = cnt_end ? ST_HOLD : ST_STROBE;
      ST_HOLD: state_nxt = cnt_end ? ST_IDLE : ST_HOLD;
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire [3:0] cnt_load = (state_r == ST_IDLE) ? `SETUP_CYC - 4'h1 :
                        (state_r == ST_SETUP) ? `STROBE_CYC - 4'h1 : `HOLD_CYC - 4'h1;
  wire state_move = (state_nxt != state_r);

  // State and timing counter
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= state_move ? cnt_load : cnt_r - 4'h1;
    end
  end

  // Request capture
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      write_r <= 1'b0;
      attr_r <= 1'b0;
      fixed_r <= 1'b0;
      size_r <= SIZE_BYTE;
      addr_r <= 11'h000;
      wdata_r <= 16'h0000;
    end else if (accept) begin
      write_r <= write_in;
      attr_r <= attr_in && !fixed_req;
      fixed_r <= fixed_req;
      size_r <= size_in;
      addr_r <= addr_in;
      wdata_r <= wdata_in;
    end
  end

  // Pin inputs pass two flip-flops
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      lanes_meta_r <= 16'h0000;
      lanes_sync_r <= 16'h0000;
      ind_meta_r <= 1'b1;
      ind_sync_r <= 1'b1;
    end else begin
      lanes_meta_r <= data_lanes_in;
      lanes_sync_r <= lanes_meta_r;
      ind_meta_r <= word_cycle_indicator_n_in;
      ind_sync_r <= ind_meta_r;
    end
  end

  lane_steer u_steer (
    .size_in(size_r),
    .addr_in(addr_r),
    .attr_in(attr_r),
    .fixed_in(fixed_r),
    .wdata_in(wdata_r),
    .low_lane_enable_n_out(low_en_n),
    .high_lane_enable_n_out(high_en_n),
    .byte_select_lsb_out(lsb),
    .lanes_out(lanes_w),
    .lane_oe_out(lane_oe_w)
  );

  // Read capture: attribute reads keep only the even byte, byte LSB-high to high half except in fixed mode
  wire odd_low = (size_r == SIZE_BYTE) && addr_r[0] && !attr_r && !fixed_r;
  wire [7:0] rd_hi = attr_r ? 8'h00 : lanes_sync_r[15:8];
  wire [7:0] rd_lo = (attr_r && (size_r == SIZE_ODD || addr_r[0])) ? 8'h00 : lanes_sync_r[7:0];
  wire [15:0] rd_word = (size_r == SIZE_ODD && !fixed_r) ? {rd_hi, 8'h00} :
                        odd_low ? {rd_lo, 8'h00} :
                        (size_r == SIZE_WORD) ? {rd_hi, rd_lo} : {8'h00, rd_lo};
  wire last_strobe = (state_r == ST_STROBE) && cnt_end;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (last_strobe && !write_r) begin
        rdata_r <= rd_word;
      end
      done_r <= (state_r == ST_HOLD) && cnt_end;
      refused_r <= idle && req_in && refuse;
    end
  end
  assign rdata_out = rdata_r;
  assign done_out = done_r;
  assign refused_out = refused_r;
  assign word_expected_out = !ind_sync_r;

  // Pin drive: address and enables stand for the whole access
  wire busy = !idle;
  wire strobe = (state_r == ST_STROBE);
  assign addr_pins_out = busy ? addr_r : 11'h000;
  assign byte_select_lsb_out = busy ? lsb : 1'b0;
  assign low_lane_enable_n_out = busy ? low_en_n : 1'b1;
  assign high_lane_enable_n_out = busy ? high_en_n : 1'b1;
  // Attribute select low for attribute and I/O-mode cycles, high for memory task file and fixed mode
  assign attr_select_n_out = fixed_r ? 1'b1 : !(attr_r || (mode_in == MAP_IO));
  wire io_map = fixed_r || (!attr_r && (mode_in == MAP_IO));
  // Output enable tied low in fixed mode to select it
  assign output_enable_n_out = (mode_in == MAP_FIXED) ? 1'b0 :
                               !(strobe && !write_r && !io_map);
  assign write_enable_n_out = !(strobe && write_r && !io_map);
  assign io_read_strobe_n_out = !(strobe && !write_r && io_map);
  assign io_write_strobe_n_out = !(strobe && write_r && io_map);
  assign data_lanes_out = lanes_w;
  assign data_lanes_oe_out = (busy && write_r) ? lane_oe_w : 16'h0000;

  // Checks
  property p_one_strobe;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(io_read_strobe_n_out) |-> !io_read_strobe_n_out [*6] ##1 io_read_strobe_n_out;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobe width wrong");
  property p_fixed_no_mem;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      fixed_r && busy |-> write_enable_n_out && !output_enable_n_out;
  endproperty
  a_fixed_no_mem: assert property (p_fixed_no_mem) else $error("memory strobe in fixed");
  property p_fixed_refuse_attr;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      idle && req_in && fixed_req && attr_in |=> refused_out && ready_out;
  endproperty
  a_fixed_refuse_attr: assert property (p_fixed_refuse_attr) else $error("attr not refused");
  property p_attr_sel;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      busy && attr_r |-> !attr_select_n_out && io_read_strobe_n_out && io_write_strobe_n_out;
  endproperty
  a_attr_sel: assert property (p_attr_sel) else $error("attribute select high");
  property p_attr_wr_lane;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      busy && attr_r && write_r |-> data_lanes_oe_out[15:8] == 8'h00;
  endproperty
  a_attr_wr_lane: assert property (p_attr_wr_lane) else $error("attr high lane driven");
  property p_fixed_enables;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      busy && fixed_r |-> low_lane_enable_n_out || high_lane_enable_n_out;
  endproperty
  a_fixed_enables: assert property (p_fixed_enables) else $error("both enables low");
  property p_mem_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !output_enable_n_out && !fixed_r |-> attr_select_n_out || attr_r;
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory read select");
  property p_done;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      accept |-> ##11 done_out;
  endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_odd_lane;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      busy && write_r && !fixed_r && size_r == SIZE_ODD |-> data_lanes_oe_out[7:0] == 8'h00;
  endproperty
  a_odd_lane: assert property (p_odd_lane) else $error("odd low lane driven");
  c_io_read: cover property (@(posedge sys_clk_in) $fell(io_read_strobe_n_out));
  c_mem_write: cover property (@(posedge sys_clk_in) $fell(write_enable_n_out));
  c_refused: cover property (@(posedge sys_clk_in) refused_out);
endmodule : card_host_access

// ---- rtl/card_host_pkg.sv ----
// Types for the card socket host access controller
package card_host_pkg;
  typedef enum logic [1:0] {
    MAP_MEMORY = 2'h0,
    MAP_IO = 2'h1,
    MAP_FIXED = 2'h2
  } map_mode_type;
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_ODD = 2'h2
  } size_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD = 4'h8
  } state_type;
endpackage : card_host_pkg

// ---- rtl/card_host_regs.svh ----
// Constants for the card socket host access controller
// Operation
// - Attribute accesses (info table, config registers) are made with attribute select low.
// - I/O task reads hold attribute select low, pulse I/O read, steer lanes.
// - Memory task reads hold attribute select high, pulse output enable, I/O strobes high.
// - Memory task writes hold attribute select high, pulse write enable only.
// - In I/O card mode attribute select stays low for all accesses.
`ifndef CARD_HOST_REGS_SVH
`define CARD_HOST_REGS_SVH
`define SETUP_CYC 4'h2
`define STROBE_CYC 4'h6
`define HOLD_CYC 4'h2
`define ALT_STATUS_ADDR 11'h006
`define DATA_REG_ADDR 11'h000
`define CFG_BASE_ADDR 11'h200
`define CFG_LAST_ADDR 11'h206
`endif

// ---- rtl/lane_steer.sv ----
// Lane steering: enables, address LSB and byte lanes for one access
`timescale 1ns/10ps
module lane_steer
  import card_host_pkg::*;
(
  input wire size_type size_in,
  input wire logic [10:0] addr_in,
  input wire logic attr_in,
  input wire logic fixed_in,
  input wire logic [15:0] wdata_in,
  output logic low_lane_enable_n_out,
  output logic high_lane_enable_n_out,
  output logic byte_select_lsb_out,
  output logic [15:0] lanes_out,
  output logic [15:0] lane_oe_out
);
  // Fixed mode: high enable alone only for alternate status / control at 6
  wire fixed_hi = fixed_in && (addr_in == `ALT_STATUS_ADDR) && (size_in == SIZE_ODD);
  wire odd_sel = (size_in == SIZE_ODD) && !fixed_in;
  wire word_sel = (size_in == SIZE_WORD);
  // Enables: never both low in fixed mode
  assign low_lane_enable_n_out = fixed_hi ? 1'b1 : odd_sel;
  assign high_lane_enable_n_out = fixed_in ? !fixed_hi : !(word_sel || odd_sel);
  assign byte_select_lsb_out = addr_in[0];
  // Byte cycle with LSB high moves odd byte on low lane; odd cycle uses high lane except in fixed mode
  // Fixed mode task file bytes always come from the low byte of the write data
  wire odd_on_low = (size_in == SIZE_BYTE) && addr_in[0] && !attr_in && !fixed_in;
  wire [7:0] low_byte = odd_on_low ? wdata_in[15:8] : wdata_in[7:0];
  assign lanes_out = {wdata_in[15:8], fixed_hi ? wdata_in[7:0] : low_byte};
  // Attribute writes only ever drive the low lane
  assign lane_oe_out[7:0] = {8{!odd_sel || fixed_hi}};
  assign lane_oe_out[15:8] = {8{(word_sel || odd_sel) && !attr_in && !fixed_hi}};
endmodule : lane_steer

// ---- testbench/card_device_model.sv ----
// Behavioural model of the storage card seen through its socket pins
`timescale 1ns/10ps
module card_device_model #(
  parameter logic [7:0] STATUS_VAL = 8'h50 // Arbitrary alternate status value
) (
  input wire logic sys_clk_in,
  input wire logic fixed_strap_in,
  input wire logic byte_mode_in,
  input wire logic [10:0] addr_in,
  input wire logic lsb_in,
  input wire logic low_en_n_in,
  input wire logic high_en_n_in,
  input wire logic attr_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic io_read_strobe_n_n_in,
  input wire logic io_write_strobe_n_n_in,
  input wire logic [15:0] bus_in,
  output logic [15:0] lanes_out,
  output logic word_ind_n_out
);
  logic [7:0] mem [0:2047];
  logic [7:0] ctrl_r = 8'h00;
  logic [15:0] junk_r = 16'h5a5a;
  // Cycle decode from the strobes
  wire [10:0] ba = {addr_in[10:1], lsb_in};
  wire [10:0] ev = {addr_in[10:1], 1'b0};
  wire [10:0] od = {addr_in[10:1], 1'b1};
  wire io_cyc = !io_read_strobe_n_n_in || !io_write_strobe_n_n_in;
  wire attr = !fixed_strap_in && !attr_n_in && !io_cyc;
  wire rd = fixed_strap_in ? !io_read_strobe_n_n_in : (!oe_n_in || !io_read_strobe_n_n_in);
  wire wr = fixed_strap_in ? !io_write_strobe_n_n_in : (!we_n_in || !io_write_strobe_n_n_in);
  wire both = !low_en_n_in && !high_en_n_in;
  // Fixed mode data register moves a whole word on the low enable until byte mode
  wire fdata = fixed_strap_in && !byte_mode_in && !low_en_n_in && (addr_in == 11'h000);
  wire word = (both && !fixed_strap_in) || fdata;
  wire inval = fixed_strap_in && both;
  wire alt = fixed_strap_in && low_en_n_in && !high_en_n_in;
  wire attr_bad = attr && lsb_in && !word;
  wire [7:0] lo_b = alt ? STATUS_VAL : attr_bad ? ~junk_r[7:0] : mem[word ? ev : ba];
  wire [7:0] hi_b = attr ? ~junk_r[15:8] : mem[od];
  wire lo_on = rd && !inval && (alt || !low_en_n_in);
  wire hi_on = rd && !inval && !alt && (!high_en_n_in || word);
  // Undriven lanes float to a pattern that changes every cycle
  assign lanes_out = {hi_on ? hi_b : junk_r[15:8], lo_on ? lo_b : junk_r[7:0]};
  assign word_ind_n_out = !(fixed_strap_in && !byte_mode_in);
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Write capture while the write strobe is low
  always @(posedge sys_clk_in) begin
    junk_r <= ~junk_r;
    if (wr && !inval) begin
      if (alt) begin
        ctrl_r <= bus_in[7:0];
      end else begin
        if (!low_en_n_in && !attr_bad) mem[word ? ev : ba] <= bus_in[7:0];
        if ((!high_en_n_in || word) && !attr) mem[od] <= bus_in[15:8];
      end
    end
  end
endmodule : card_device_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the card socket host controller
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module tb_top
  import card_host_pkg::*;
;
  typedef struct packed {logic refd; logic [15:0] mask; logic [15:0] val;} note_type;
  note_type notes[$];
  note_type cur;
  int fails = 0;
  int tests_run = 0;
  logic sys_clk_in = 0, rst_n_in = 0, req = 0, wr = 0, attr = 0, bm = 0, fixed = 0;
  map_mode_type mode = MAP_MEMORY;
  size_type size = SIZE_BYTE;
  logic [10:0] addr = 11'h000;
  logic [15:0] wdata = 16'h0000, d, e;
  logic ready_out, done_out, refused_out, word_expected_out, lsb, attr_n, oe_n, we_n;
  logic io_read_strobe_n_n, io_write_strobe_n_n, lo_n, hi_n, ind_n;
  logic [15:0] rdata_out, lanes_out, lanes_oe, dev_lanes;
  logic [10:0] addr_pins;
  wire [15:0] bus = (lanes_oe & lanes_out) | (~lanes_oe & dev_lanes);
  always #2.5 sys_clk_in = ~sys_clk_in;
  card_host_access i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .mode_in(mode),
    .req_in(req), .write_in(wr), .attr_in(attr), .size_in(size), .addr_in(addr),
    .wdata_in(wdata), .byte_mode_in(bm), .ready_out(ready_out), .done_out(done_out),
    .refused_out(refused_out), .rdata_out(rdata_out), .word_expected_out(word_expected_out),
    .data_lanes_in(bus), .word_cycle_indicator_n_in(ind_n), .data_lanes_out(lanes_out),
    .data_lanes_oe_out(lanes_oe), .addr_pins_out(addr_pins), .byte_select_lsb_out(lsb),
    .low_lane_enable_n_out(lo_n), .high_lane_enable_n_out(hi_n), .attr_select_n_out(attr_n),
    .output_enable_n_out(oe_n), .write_enable_n_out(we_n), .io_read_strobe_n_out(io_read_strobe_n_n),
    .io_write_strobe_n_out(io_write_strobe_n_n));
  card_device_model i_dev (.sys_clk_in(sys_clk_in), .fixed_strap_in(fixed),
    .byte_mode_in(bm), .addr_in(addr_pins), .lsb_in(lsb), .low_en_n_in(lo_n),
    .high_en_n_in(hi_n), .attr_n_in(attr_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .io_read_strobe_n_n_in(io_read_strobe_n_n), .io_write_strobe_n_n_in(io_write_strobe_n_n), .bus_in(bus), .lanes_out(dev_lanes),
    .word_ind_n_out(ind_n));
  task final_report;
    $display("Counts: %0d fails of %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Expected strobe pins {attr, oe, we, io_read_strobe_n, io_write_strobe_n} for this mode and cycle kind
  function automatic logic [4:0] pins(input logic w, input logic a);
    logic io;
    io = (mode != MAP_MEMORY) && !a;
    return {(mode == MAP_FIXED) || (mode == MAP_MEMORY && !a),
      (mode == MAP_FIXED) ? 1'b0 : !(!w && !io), !(w && !io), !(io && !w), !(io && w)};
  endfunction : pins
  // One access: drive, note the expectation, check pins mid-strobe, await completion
  task access(input logic w, a, size_type s, logic [10:0] ad, logic [15:0] dv,
              input logic refd, logic [15:0] m, logic [15:0] v);
    int n;
    logic [1:0] en;
    // Fixed mode word cycles use the low enable alone
    en = (s == SIZE_ODD) ? 2'b01 : (s == SIZE_WORD && mode != MAP_FIXED) ? 2'b00 : 2'b10;
    wr = w; attr = a; size = s; addr = ad; wdata = dv; req = 1;
    n = 0;
    while (ready_out !== 1'b1 && n < 40) begin @(negedge sys_clk_in); n++; end
    notes.push_back({refd, m, v});
    @(negedge sys_clk_in);
    req = 0;
    if (!refd) begin
      repeat (4) @(negedge sys_clk_in);
      `CHK({attr_n, oe_n, we_n, io_read_strobe_n_n, io_write_strobe_n_n}, pins(w, a))
      `CHK({hi_n, lo_n}, en)
      `CHK({addr_pins, lsb}, {ad, ad[0]})
    end else begin
      `CHK({io_read_strobe_n_n, io_write_strobe_n_n, we_n, hi_n, lo_n}, 5'h1f)
    end
    while ((ready_out !== 1'b1 || notes.size() > 0) && n < 80) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 80) begin fails++; final_report(); end
  endtask : access
  // Result watcher: pairs each done or refusal with the oldest note
  always @(negedge sys_clk_in) begin
    if (done_out === 1'b1 || refused_out === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("Error at %0t ns: result with no pending access", $time);
      end else begin
        cur = notes.pop_front();
        `CHK(refused_out, cur.refd)
        `CHK(rdata_out & cur.mask, cur.val)
      end
    end
  end
  initial begin
    void'($urandom(32'h9f38));
    d = $urandom;
    e = $urandom;
    repeat (12) @(negedge sys_clk_in);
    rst_n_in = 1;
    `CHK({ready_out, io_read_strobe_n_n, io_write_strobe_n_n, we_n, lo_n, hi_n}, 6'h3f)
    access(1, 0, SIZE_WORD, 11'h010, d, 0, 16'h0000, 16'h0000);
    access(0, 0, SIZE_WORD, 11'h010, 16'h0000, 0, 16'hffff, d);
    access(0, 0, SIZE_BYTE, 11'h011, 16'h0000, 0, 16'hff00, d & 16'hff00);
    access(1, 0, SIZE_ODD, 11'h010, e, 0, 16'h0000, 16'h0000);
    access(0, 0, SIZE_WORD, 11'h010, 16'h0000, 0, 16'hffff, {e[15:8], d[7:0]});
    access(1, 1, SIZE_WORD, 11'h020, e, 0, 16'h0000, 16'h0000);
    access(1, 1, SIZE_ODD, 11'h020, ~e, 0, 16'h0000, 16'h0000);
    access(0, 1, SIZE_WORD, 11'h020, 16'h0000, 0, 16'hffff, {8'h00, e[7:0]});
    access(0, 1, SIZE_BYTE, 11'h021, 16'h0000, 0, 16'hffff, 16'h0000);
    mode = MAP_IO;
    access(1, 0, SIZE_WORD, 11'h030, d, 0, 16'h0000, 16'h0000);
    access(1, 0, SIZE_BYTE, 11'h031, {e[7:0], e[7:0]}, 0, 16'h0000, 16'h0000);
    access(0, 0, SIZE_WORD, 11'h030, 16'h0000, 0, 16'hffff, {e[7:0], d[7:0]});
    access(1, 1, SIZE_BYTE, 11'h200, {d[15:8], d[15:8]}, 0, 16'h0000, 16'h0000);
    access(0, 1, SIZE_BYTE, 11'h200, 16'h0000, 0, 16'h00ff, {8'h00, d[15:8]});
    mode = MAP_FIXED;
    fixed = 1;
    repeat (4) @(negedge sys_clk_in);
    `CHK(word_expected_out, 1'b1)
    access(1, 0, SIZE_WORD, 11'h000, d, 0, 16'h0000, 16'h0000);
    access(0, 0, SIZE_WORD, 11'h000, 16'h0000, 0, 16'hffff, d);
    access(1, 0, SIZE_BYTE, 11'h002, {e[7:0], e[7:0]}, 0, 16'h0000, 16'h0000);
    access(0, 0, SIZE_BYTE, 11'h002, 16'h0000, 0, 16'h00ff, {8'h00, e[7:0]});
    access(1, 0, SIZE_ODD, 11'h006, {e[15:8], e[15:8]}, 0, 16'h0000, 16'h0000);
    `CHK(i_dev.ctrl_r, e[15:8])
    access(0, 0, SIZE_ODD, 11'h006, 16'h0000, 0, 16'h00ff, {8'h00, i_dev.STATUS_VAL});
    access(0, 1, SIZE_BYTE, 11'h002, 16'h0000, 1, 16'h0000, 16'h0000);
    access(1, 1, SIZE_BYTE, 11'h200, d, 1, 16'h0000, 16'h0000);
    access(0, 0, SIZE_BYTE, 11'h000, 16'h0000, 1, 16'h0000, 16'h0000);
    access(0, 0, SIZE_ODD, 11'h003, 16'h0000, 1, 16'h0000, 16'h0000);
    bm = 1;
    repeat (4) @(negedge sys_clk_in);
    `CHK(word_expected_out, 1'b0)
    access(0, 0, SIZE_BYTE, 11'h000, 16'h0000, 0, 16'h00ff, {8'h00, d[7:0]});
    final_report();
  end
endmodule : tb_top
